// *** core/rtc_calendar_core.sv ***
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_calendar_core
  import rtc_pkg::*;
#(
  parameter int OSC_LOSS_CYCLES = `OSC_LOSS_NS / `SYS_PERIOD_NS
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Two-wire bus pins
  input  wire logic scl,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  // Oscillator pins
  input  wire logic crystalIn,
  output logic      crystalOut,
  // Supply monitor
  input  wire logic supplyLow,
  // Open-drain outputs
  output logic      irqOut,
  output logic      irqOe,
  output logic      programmableFreqOut,
  output logic      programmableFreqOutOe
);
  localparam int LW = $clog2(OSC_LOSS_CYCLES + 1);

  logic [7:0]        regs [16];
  logic [3:0]        sy1, sy2, sy3, pinLvl;
  logic              oscQ, oscTick, oscLost;
  logic [LW-1:0]     lossCnt;
  logic [`DIV_W-1:0] divCount, carry;
  logic              busy, secPending, applyTick, minuteTick;
  reg_wr_t           wrReq;
  logic [3:0]        regPtr;
  logic [7:0]        rdData, timerCount;
  logic              timerFire, timerPulse, alarmHit, srcTick, freqLvl;
  logic [8:0]        stS, stM, stH, stD, stW, stMo, stY;
  logic              cM, cH, cD, cMo, cY;
  logic              af, tf, stop;

  // Implemented bits of each register
  function automatic logic [7:0] maskOf(input logic [3:0] a);
    case (a)
      `ADR_CTRL1:  maskOf = `MSK_CTRL1;
      `ADR_CTRL2:  maskOf = `MSK_CTRL2;
      `ADR_MIN:    maskOf = `MSK_MIN;
      `ADR_HOUR,
      `ADR_DAY:    maskOf = `MSK_HRDAY;
      `ADR_WDAY:   maskOf = `MSK_WDAY;
      `ADR_MON:    maskOf = `MSK_MON;
      `ADR_AHOUR,
      `ADR_ADAY:   maskOf = `MSK_AHRDAY;
      `ADR_AWDAY:  maskOf = `MSK_AWDAY;
      `ADR_PROGRAMMABLE_FREQ_OUT,
      `ADR_TIMCTL: maskOf = `MSK_CTLSEL;
      default:     maskOf = `MSK_FULL;
    endcase
  endfunction : maskOf

  // Value taken at reset, undefined fields come up zero
  function automatic logic [7:0] resetOf(input logic [3:0] a);
    case (a)
      `ADR_CTRL1:  resetOf = `RST_CTRL1;
      `ADR_SEC, `ADR_AMIN, `ADR_AHOUR, `ADR_ADAY, `ADR_AWDAY,
      `ADR_PROGRAMMABLE_FREQ_OUT: resetOf = `RST_TOPSET;
      `ADR_TIMCTL: resetOf = `RST_TIMCTL;
      default:     resetOf = `RST_ZERO;
    endcase
  endfunction : resetOf

  // One BCD count step, top bit flags the wrap
  function automatic logic [8:0] bcdStep(input logic [7:0] v,
                                         input logic [7:0] last,
                                         input logic [7:0] first);
    if (v == last) bcdStep = {1'b1, first};
    else if (v[3:0] == 4'h9) bcdStep = {1'b0, v[7:4] + 4'h1, 4'h0};
    else bcdStep = {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction : bcdStep

  // Last day of a BCD month, leap years every fourth year
  function automatic logic [7:0] lastDay(input logic [7:0] mon,
                                         input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02:   lastDay = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
      default: lastDay = 8'h31;
    endcase
  endfunction : lastDay

  // Pin synchronisers, a level counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sy1    <= `PIN_IDLE;
      sy2    <= `PIN_IDLE;
      sy3    <= `PIN_IDLE;
      pinLvl <= `PIN_IDLE;
    end else begin
      sy1 <= {supplyLow, crystalIn, sdaIn, scl};
      sy2 <= sy1;
      sy3 <= sy2;
      for (int i = 0; i < 4; i++) begin
        if (sy2[i] == sy3[i]) pinLvl[i] <= sy3[i];
      end
    end
  end

  // Crystal edge, inverter output and loss watchdog
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oscQ       <= 1'b0;
      crystalOut <= 1'b1;
      lossCnt    <= LW'(OSC_LOSS_CYCLES); // Lost until a first edge
      oscLost    <= 1'b1;
    end else begin
      oscQ       <= pinLvl[2];
      crystalOut <= ~pinLvl[2];
      if (oscTick) lossCnt <= '0;
      else if (lossCnt != LW'(OSC_LOSS_CYCLES)) lossCnt <= lossCnt + LW'(1);
      oscLost <= (lossCnt == LW'(OSC_LOSS_CYCLES));
    end
  end
  assign oscTick = pinLvl[2] & ~oscQ;
  assign stop    = regs[`ADR_CTRL1][`B_STOP];

  rtc_prescaler #(.DIV_W(`DIV_W)) u_prescaler (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .oscTick  (oscTick),
    .stopDiv  (stop),
    .divCount (divCount),
    .carry    (carry)
  );

  rtc_i2c_port u_bus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .softRst (oscLost),
    .sclLvl  (pinLvl[0]),
    .sdaLvl  (pinLvl[1]),
    .sdaOut  (sdaOut),
    .sdaOe   (sdaOe),
    .busy    (busy),
    .wrReq   (wrReq),
    .regPtr  (regPtr),
    .rdData  (rdData)
  );

  // Read data, timer register shows the running count
  assign rdData = (regPtr == `ADR_TIMVAL) ? timerCount
                : regs[regPtr] & maskOf(regPtr);

  // Seconds tick held back while the bus is active
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      secPending <= 1'b0;
      minuteTick <= 1'b0;
    end else begin
      if (carry[`TAP_1HZ]) secPending <= 1'b1;
      else if (applyTick) secPending <= 1'b0;
      minuteTick <= applyTick & cM;
    end
  end
  assign applyTick = secPending & ~busy & ~stop;

  // Next calendar values
  assign stS  = bcdStep({1'b0, regs[`ADR_SEC][6:0]}, 8'h59, 8'h00);
  assign stM  = bcdStep({1'b0, regs[`ADR_MIN][6:0]}, 8'h59, 8'h00);
  assign stH  = bcdStep({2'b00, regs[`ADR_HOUR][5:0]}, 8'h23, 8'h00);
  assign stD  = bcdStep({2'b00, regs[`ADR_DAY][5:0]},
                        lastDay({3'b000, regs[`ADR_MON][4:0]},
                                regs[`ADR_YEAR]), 8'h01);
  assign stW  = bcdStep({5'h00, regs[`ADR_WDAY][2:0]}, 8'h06, 8'h00);
  assign stMo = bcdStep({3'b000, regs[`ADR_MON][4:0]}, 8'h12, 8'h01);
  assign stY  = bcdStep(regs[`ADR_YEAR], 8'h99, 8'h00);
  assign cM   = stS[8];
  assign cH   = cM & stM[8];
  assign cD   = cH & stH[8];
  assign cMo  = cD & stD[8];
  assign cY   = cMo & stMo[8];

  // Alarm compare after each minute step, AE bit low enables a field
  assign alarmHit = minuteTick & ~(&{regs[`ADR_AMIN][`B_TOP],
      regs[`ADR_AHOUR][`B_TOP], regs[`ADR_ADAY][`B_TOP],
      regs[`ADR_AWDAY][`B_TOP]})
    & (regs[`ADR_AMIN][`B_TOP]
       | (regs[`ADR_AMIN][6:0] == regs[`ADR_MIN][6:0]))
    & (regs[`ADR_AHOUR][`B_TOP]
       | (regs[`ADR_AHOUR][5:0] == regs[`ADR_HOUR][5:0]))
    & (regs[`ADR_ADAY][`B_TOP]
       | (regs[`ADR_ADAY][5:0] == regs[`ADR_DAY][5:0]))
    & (regs[`ADR_AWDAY][`B_TOP]
       | (regs[`ADR_AWDAY][2:0] == regs[`ADR_WDAY][2:0]));

  assign af = regs[`ADR_CTRL2][`B_AF];
  assign tf = regs[`ADR_CTRL2][`B_TF];

  // Register file: calendar steps, bus writes, sticky flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) regs[i] <= resetOf(4'(i));
    end else begin
      if (applyTick) begin
        regs[`ADR_SEC][6:0] <= stS[6:0];
        if (cM) regs[`ADR_MIN] <= stM[7:0];
        if (cH) regs[`ADR_HOUR] <= stH[7:0];
        if (cD) regs[`ADR_DAY] <= stD[7:0];
        if (cD) regs[`ADR_WDAY] <= stW[7:0];
        if (cMo) regs[`ADR_MON][4:0] <= stMo[4:0];
        if (cY) regs[`ADR_YEAR] <= stY[7:0];
        if (cY && stY[8])
          regs[`ADR_MON][`B_TOP] <= ~regs[`ADR_MON][`B_TOP];
      end
      if (wrReq.en)
        regs[wrReq.addr] <= wrReq.data & maskOf(wrReq.addr);
      if (pinLvl[3]) regs[`ADR_SEC][`B_TOP] <= 1'b1;
      // Writing one keeps a flag, zero clears it, a new event wins
      regs[`ADR_CTRL2][`B_AF] <= (af & ~(wrReq.en
        && wrReq.addr == `ADR_CTRL2 && !wrReq.data[`B_AF])) | alarmHit;
      regs[`ADR_CTRL2][`B_TF] <= (tf & ~(wrReq.en
        && wrReq.addr == `ADR_CTRL2 && !wrReq.data[`B_TF])) | timerFire;
    end
  end

  // Countdown source select
  always_comb begin
    case (regs[`ADR_TIMCTL][1:0])
      2'h0:    srcTick = carry[`TAP_4K];
      2'h1:    srcTick = carry[`TAP_64];
      2'h2:    srcTick = carry[`TAP_1HZ];
      default: srcTick = minuteTick;
    endcase
  end

  // Countdown, reloads from the timer register when it runs out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timerCount <= 8'h00;
      timerFire  <= 1'b0;
      timerPulse <= 1'b0;
    end else begin
      timerFire <= 1'b0;
      if (wrReq.en && wrReq.addr == `ADR_TIMVAL) begin
        timerCount <= wrReq.data;
      end else if (regs[`ADR_TIMCTL][`B_TOP] && srcTick
                   && timerCount != 8'h00) begin
        if (timerCount == 8'h01) begin
          timerCount <= regs[`ADR_TIMVAL];
          timerFire  <= 1'b1;
        end else begin
          timerCount <= timerCount - 8'h01;
        end
      end
      if (timerFire) timerPulse <= 1'b1;
      else if (carry[`TAP_4K]) timerPulse <= 1'b0;
    end
  end

  // Clock output tap selection
  always_comb begin
    case (regs[`ADR_PROGRAMMABLE_FREQ_OUT][1:0])
      2'h0:    freqLvl = pinLvl[2];
      2'h1:    freqLvl = divCount[`TAP_1K];
      2'h2:    freqLvl = divCount[`TAP_32];
      default: freqLvl = divCount[`TAP_1HZ];
    endcase
  end

  // Open-drain drives: enable pulls the pin low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqOe                 <= 1'b0;
      programmableFreqOutOe <= 1'b0;
    end else begin
      irqOe <= (af & regs[`ADR_CTRL2][`B_AIE])
             | (regs[`ADR_CTRL2][`B_TIE]
                & (regs[`ADR_CTRL2][`B_PULSE] ? timerPulse : tf));
      programmableFreqOutOe <= regs[`ADR_PROGRAMMABLE_FREQ_OUT][`B_TOP] & ~freqLvl;
    end
  end
  assign irqOut              = 1'b0;
  assign programmableFreqOut = 1'b0;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_irq_alarm:
    assert property (af && regs[`ADR_CTRL2][`B_AIE] |=> irqOe)
    else $error("alarm flag with enable did not pull interrupt");
  a_stop_halts:
    assert property (stop && $past(stop) |-> divCount == '0 && !applyTick)
    else $error("divider running while stopped");
  a_read_freeze:
    assert property (busy && !wrReq.en
                     |=> $stable(regs[`ADR_SEC][6:0]))
    else $error("seconds moved during a bus transfer");
  a_vl_set:
    assert property (pinLvl[3] |=> regs[`ADR_SEC][`B_TOP])
    else $error("voltage low flag not set");
  a_timer_flag:
    assert property (timerFire |=> tf ##1 tf || $past(wrReq.en))
    else $error("timer flag not set on expiry");
  a_freq_full:
    assert property (regs[`ADR_PROGRAMMABLE_FREQ_OUT][`B_TOP]
                     && regs[`ADR_PROGRAMMABLE_FREQ_OUT][1:0] == 2'h0
                     |=> programmableFreqOutOe == !$past(pinLvl[2]))
    else $error("full-rate clock output wrong");
  c_alarm: cover property (alarmHit);
  c_timer: cover property (timerFire);
  c_year: cover property (applyTick && cY);
endmodule : rtc_calendar_core

// *** core/rtc_cfg.svh ***
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// Register offsets
`define ADR_CTRL1  4'h0
`define ADR_CTRL2  4'h1
`define ADR_SEC    4'h2
`define ADR_MIN    4'h3
`define ADR_HOUR   4'h4
`define ADR_DAY    4'h5
`define ADR_WDAY   4'h6
`define ADR_MON    4'h7
`define ADR_YEAR   4'h8
`define ADR_AMIN   4'h9
`define ADR_AHOUR  4'hA
`define ADR_ADAY   4'hB
`define ADR_AWDAY  4'hC
`define ADR_PROGRAMMABLE_FREQ_OUT 4'hD
`define ADR_TIMCTL 4'hE
`define ADR_TIMVAL 4'hF
// Seven-bit bus address, write form A2h and read form A3h
`define SLAVE_ADDR 7'h51
`define BYTE_BITS  4'h8
// Field positions
`define B_STOP  5
`define B_PULSE 4
`define B_AF    3
`define B_TF    2
`define B_AIE   1
`define B_TIE   0
`define B_TOP   7
// Reset values
`define RST_CTRL1  8'h08
`define RST_TOPSET 8'h80
`define RST_TIMCTL 8'h03
`define RST_ZERO   8'h00
`define PIN_IDLE   4'h3
// Implemented bits per register
`define MSK_CTRL1  8'hA8
`define MSK_CTRL2  8'h1F
`define MSK_MIN    8'h7F
`define MSK_HRDAY  8'h3F
`define MSK_WDAY   8'h07
`define MSK_MON    8'h9F
`define MSK_AHRDAY 8'hBF
`define MSK_AWDAY  8'h87
`define MSK_CTLSEL 8'h83
`define MSK_FULL   8'hFF
// Prescaler width and taps
`define DIV_W   15
`define TAP_4K  2
`define TAP_64  8
`define TAP_1K  4
`define TAP_32  9
`define TAP_1HZ 14
// Timing
`define SYS_PERIOD_NS 20
`define OSC_LOSS_NS   122000
`endif

// *** core/rtc_pkg.sv ***
package rtc_pkg;
  // Bus slave sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b011,
    ST_ACK   = 3'b100,
    ST_MACK  = 3'b101
  } i2c_state_t;

  // Register write request from the bus slave
  typedef struct packed {
    logic       en;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_wr_t;
endpackage : rtc_pkg

// *** core/rtc_prescaler.sv ***
`timescale 1ns/1ps
module rtc_prescaler
  import rtc_pkg::*;
#(
  parameter int DIV_W = 15
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Oscillator edge and stop control
  input  wire logic             oscTick,
  input  wire logic             stopDiv,
  // Divider state and per-stage carries
  output logic [DIV_W-1:0]      divCount,
  output logic [DIV_W-1:0]      carry
);
  // Ripple count of oscillator edges, cleared while stopped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= '0;
    end else if (stopDiv) begin
      divCount <= '0;
    end else if (oscTick) begin
      divCount <= divCount + DIV_W'(1);
    end
  end

  // Stage k carries when it and all lower stages are at one
  genvar k;
  for (k = 0; k < DIV_W; k++) begin : g_carry
    assign carry[k] = oscTick & ~stopDiv & (&divCount[k:0]);
  end
endmodule : rtc_prescaler

// *** core/rtc_i2c_port.sv ***
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_i2c_port
  import rtc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       softRst,
  // Filtered pin levels and data drive
  input  wire logic       sclLvl,
  input  wire logic       sdaLvl,
  output logic            sdaOut,
  output logic            sdaOe,
  // Register side
  output logic            busy,
  output reg_wr_t         wrReq,
  output logic [3:0]      regPtr,
  input  wire logic [7:0] rdData
);
  i2c_state_t state;
  logic       sclQ;
  logic       sdaQ;
  logic       isRead;
  logic       firstByte;
  logic [3:0] bitCnt;
  logic [7:0] shift;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       byteDone;
  logic       addrHit;

  // Bus events from the previous levels
  assign sclRise   = sclLvl & ~sclQ;
  assign sclFall   = ~sclLvl & sclQ;
  assign startCond = sclLvl & sclQ & sdaQ & ~sdaLvl;
  assign stopCond  = sclLvl & sclQ & ~sdaQ & sdaLvl;
  assign byteDone  = sclFall && (bitCnt == `BYTE_BITS);
  assign addrHit   = (shift[7:1] == `SLAVE_ADDR);
  assign sdaOut    = 1'b0; // Open drain, only the enable moves

  // Level history
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclQ <= sclLvl;
      sdaQ <= sdaLvl;
    end
  end

  // Bit sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      shift     <= 8'h00;
      isRead    <= 1'b0;
      firstByte <= 1'b0;
      sdaOe     <= 1'b0;
      busy      <= 1'b0;
    end else if (softRst || stopCond) begin
      state <= ST_IDLE;
      sdaOe <= 1'b0;
      busy  <= 1'b0;
    end else if (startCond) begin
      state     <= ST_ADDR;
      bitCnt    <= 4'h0;
      sdaOe     <= 1'b0;
      busy      <= 1'b1;
      firstByte <= 1'b1;
    end else begin
      case (state)
        ST_ADDR, ST_WRITE: begin
          if (sclRise) begin
            shift  <= {shift[6:0], sdaLvl};
            bitCnt <= bitCnt + 4'h1;
          end else if (byteDone) begin
            bitCnt <= 4'h0;
            if (state == ST_WRITE || addrHit) begin
              sdaOe <= 1'b1;
              state <= ST_ACK;
            end else begin
              state <= ST_IDLE;
              busy  <= 1'b0;
            end
            if (state == ST_ADDR) isRead <= shift[0];
            else firstByte <= 1'b0;
          end
        end
        ST_ACK: begin
          if (sclFall && isRead) begin
            sdaOe  <= ~rdData[7];
            shift  <= {rdData[6:0], 1'b0};
            bitCnt <= 4'h1;
            state  <= ST_READ;
          end else if (sclFall) begin
            sdaOe <= 1'b0;
            state <= ST_WRITE;
          end
        end
        ST_READ: begin
          if (byteDone) begin
            sdaOe <= 1'b0;
            state <= ST_MACK;
          end else if (sclFall) begin
            sdaOe  <= ~shift[7];
            shift  <= {shift[6:0], 1'b0};
            bitCnt <= bitCnt + 4'h1;
          end
        end
        ST_MACK: begin
          if (sclRise) state <= sdaLvl ? ST_IDLE : ST_ACK;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Word pointer and register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regPtr <= 4'h0;
      wrReq  <= '0;
    end else begin
      wrReq.en <= 1'b0;
      if (softRst) begin
        regPtr <= 4'h0;
      end else if (byteDone && state == ST_WRITE) begin
        if (firstByte) begin
          regPtr <= shift[3:0];
        end else begin
          wrReq  <= '{en: 1'b1, addr: regPtr, data: shift};
          regPtr <= regPtr + 4'h1;
        end
      end else if (byteDone && state == ST_READ) begin
        regPtr <= regPtr + 4'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_addr_ack:
    assert property (state == ST_ADDR && byteDone && addrHit && !softRst
                     |=> sdaOe && state == ST_ACK)
    else $error("own address not acknowledged");
  a_write_step:
    assert property (state == ST_WRITE && byteDone && !firstByte && !softRst
                     |=> wrReq.en && regPtr == $past(regPtr) + 4'h1)
    else $error("write byte did not store and advance");
  a_read_step:
    assert property (state == ST_READ && byteDone && !softRst
                     |=> regPtr == $past(regPtr) + 4'h1)
    else $error("pointer not advanced after read byte");
  a_soft_reset:
    assert property (softRst |=> state == ST_IDLE && regPtr == 4'h0 && !sdaOe)
    else $error("bus logic not reset while oscillator stopped");
  c_write_byte: cover property (wrReq.en);
  c_read_byte: cover property (state == ST_READ && byteDone);
endmodule : rtc_i2c_port

// *** verif/i2c_master_model.sv ***
`timescale 1ns/1ps
// Two-wire bus master, each SCL phase at least HALF system clocks
module i2c_master_model #(
  parameter int HALF = 63
) (
  // Clock
  input  wire logic clk_sys,
  // Bus wires, sdaLow high pulls SDA down
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  // Bus idles released, pulled up
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : hold

  // START, also repeated START from SCL low
  task automatic start();
    hold(8);
    sdaLow = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sdaLow = 1'b1;
    hold(HALF);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    hold(8);
    sdaLow = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sdaLow = 1'b0;
    hold(HALF);
  endtask : stop

  // Data settles well after SCL fall, sampled at end of high phase
  task automatic sendBit(input logic b, output logic r);
    hold(8);
    sdaLow = ~b;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    r = sdaLine;
    scl = 1'b0;
  endtask : sendBit

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) sendBit(b[i], r);
    sendBit(1'b1, r);
    ack = ~r;
  endtask : sendByte

  // Acknowledge unless last byte
  task automatic recvByte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      sendBit(1'b1, r);
      b[i] = r;
    end
    sendBit(last, r);
  endtask : recvByte
endmodule : i2c_master_model

// *** verif/rtc_calendar_register_map_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errorCnt++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module rtc_calendar_register_map_tb_top import rtc_pkg::*;;
  localparam int LIMIT = 110000;
  logic       clk_sys;
  logic       rst_n;
  logic       crystalIn;
  logic       supplyLow;
  logic       scl;
  logic       mstLow;
  logic       sdaOut;
  logic       sdaOe;
  logic       irqOut;
  logic       irqOe;
  logic       fOut;
  logic       fOe;
  logic       crOut;
  wire logic  sdaLine;
  int         errorCnt = 0;
  int         nTests = 0;
  int         cyc = 0;
  int         n;
  logic       a;
  logic [7:0] q[$];
  logic [7:0] d[$];

  // Open-drain data wire with pull-up
  assign sdaLine = ~(sdaOe | mstLow);

  rtc_calendar_core #(.OSC_LOSS_CYCLES(64)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .crystalIn(crystalIn),
    .crystalOut(crOut), .supplyLow(supplyLow), .irqOut(irqOut),
    .irqOe(irqOe), .programmableFreqOut(fOut),
    .programmableFreqOutOe(fOe));

  i2c_master_model #(.HALF(63)) i_mst (
    .clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl), .sdaLow(mstLow));

  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Crystal, 20 system clocks per period, unrelated phase
  initial begin
    crystalIn = 1'b0;
    #7;
    forever #200 crystalIn = ~crystalIn;
  end

  function automatic logic [7:0] mask(input int r);
    case (r)
      0: return 8'hA8;
      1: return 8'h1F;
      3: return 8'h7F;
      4, 5: return 8'h3F;
      6: return 8'h07;
      7: return 8'h9F;
      10, 11: return 8'hBF;
      12: return 8'h87;
      13, 14: return 8'h83;
      default: return 8'hFF;
    endcase
  endfunction : mask

  function automatic logic [7:0] rstVal(input int r);
    case (r)
      0: return 8'h08;
      2, 9, 10, 11, 12, 13: return 8'h80;
      14: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : rstVal

  task automatic test_done();
    $display("checks %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic put(input logic [7:0] b);
    i_mst.sendByte(b, a);
    `CHK("ack", 1'b1, a)
  endtask : put

  // Write queue d from pointer p
  task automatic wrRegs(input logic [3:0] p);
    i_mst.start();
    put(8'hA2);
    put({4'h0, p});
    foreach (d[i]) put(d[i]);
    i_mst.stop();
  endtask : wrRegs

  // Read cnt bytes from pointer p into queue q
  task automatic rdRegs(input logic [3:0] p, input int cnt);
    logic [7:0] b;
    q = {};
    i_mst.start();
    put(8'hA2);
    put({4'h0, p});
    i_mst.start();
    put(8'hA3);
    for (int i = 0; i < cnt; i++) begin
      i_mst.recvByte(i == cnt - 1, b);
      q.push_back(b);
    end
    i_mst.stop();
  endtask : rdRegs

  // Cycle ceiling against a hung bus
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      errorCnt++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'hBBF6));
    rst_n = 1'b0;
    supplyLow = 1'b0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (100) @(negedge clk_sys);
    // Short supply dip, the flag is already set from reset
    supplyLow = 1'b1;
    repeat (10) @(negedge clk_sys);
    supplyLow = 1'b0;
    repeat (90) @(negedge clk_sys);
    rdRegs(4'h0, 17);
    for (int i = 0; i < 17; i++) `CHK("rst", rstVal(i % 16), q[i])
    $display("done reset map");
    d = {};
    for (int i = 3; i <= 12; i++) d.push_back(8'($urandom));
    wrRegs(4'h3);
    rdRegs(4'h3, 10);
    for (int i = 0; i < 10; i++) `CHK("rw", d[i] & mask(i + 3), q[i])
    $display("done random write");
    i_mst.start();
    i_mst.sendByte(8'hA4, a);
    `CHK("nack", 1'b0, a)
    i_mst.stop();
    $display("done foreign address");
    d = {8'h80, 8'h01};
    wrRegs(4'hE);
    repeat (600) @(negedge clk_sys);
    rdRegs(4'h1, 1);
    `CHK("tf", 8'h04, q[0])
    `CHK("irqMask", 1'b0, irqOe)
    d = {8'h05};
    wrRegs(4'h1);
    repeat (20) @(negedge clk_sys);
    `CHK("irqOn", 1'b1, irqOe)
    `CHK("irqPin", 1'b0, irqOut)
    `CHK("sdaPin", 1'b0, sdaOut)
    // Timer off, value zero, then across the wrap time is stopped
    d = {8'h03, 8'h00, 8'h20};
    wrRegs(4'hE);
    d = {8'h01};
    wrRegs(4'h1);
    repeat (20) @(negedge clk_sys);
    `CHK("irqClr", 1'b0, irqOe)
    $display("done interrupt");
    for (int fd = 0; fd < 2; fd++) begin
      // Full rate while stopped, then 1.024 kHz with time running again
      if (fd == 0) d = {8'h80};
      else d = {8'h81, 8'h03, 8'h00, 8'h00};
      wrRegs(4'hD);
      @(posedge fOe);
      @(negedge clk_sys);
      n = 0;
      while (fOe === 1'b1 && n < 2000) begin
        @(negedge clk_sys);
        n++;
      end
      while (fOe !== 1'b1 && n < 2000) begin
        @(negedge clk_sys);
        n++;
      end
      `CHK("period", (fd == 0) ? 20 : 640, n)
      `CHK("fPin", 1'b0, fOut)
      if (fd == 0) `CHK("xtalOut", 1'b1, crOut)
    end
    $display("done clock output");
    test_done();
  end
endmodule : rtc_calendar_register_map_tb_top
